// ==== design/cmx_move_exec.sv ====
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - A file move copies the addressed byte to the work register when the destination bit is 0, or writes it back to the same byte when it is 1.
// - A file move updates the zero flag from the moved byte, so a write-back tests the byte for zero.
// - An indirect load puts the byte read through the indirect window into the work register and updates the zero flag from it.
// - The indirect window has no storage and every access to it goes to the address held in the selected pointer.
// - Pointer mode 00 is preincrement, 01 predecrement, 10 postincrement and 11 postdecrement, pre modes stepping before the access and post modes after.
// - After an indirect load the pointer holds old plus one for increments, old minus one for decrements, and is unchanged for the offset form.
// - In the offset form the address is the selected one of two pointers plus a signed offset from -32 to 31.
// - Each pointer is 16 bits and wraps around past 0000h and FFFFh.
// - The bank literal load writes its 5-bit immediate into the bank select register.
// - The page latch literal load writes its 7-bit immediate into the page latch and touches no flag.
// - The work literal load writes its 8-bit immediate into the work register and touches no flag.
// - The store of the work register writes it to the file byte at the 7-bit address and touches no flag.
// - Pointer steps of the indirect moves never change any status flag.
module cmx_move_exec
	import cmx_pkg::*;
#(
	parameter int unsigned MEM_DEPTH = 256
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Core state seen by the rest of the core
	output logic      [7:0]  work_reg,
	output logic             zero_flag,
	output logic      [4:0]  bank_select,
	output logic      [6:0]  pc_high_latch
);

	localparam int unsigned IDX_W = $clog2(MEM_DEPTH);

	cmx_bus_t               st_q;
	logic [CMX_OFF_W-1:0]   addr_q;
	logic [31:0]            hrdata_q;
	logic                   hreadyout_q;
	logic                   hresp_q;
	logic [7:0]             w_q;
	logic                   zero_q;
	logic [4:0]             bank_q;
	logic [6:0]             page_q;
	logic [CMX_PTR_W-1:0]   ptr_q [CMX_PTR_NUM];
	logic [CMX_PTR_W-1:0]   maddr_q;
	logic [7:0]             mem_q [MEM_DEPTH];
	logic                   accept;
	logic                   wr;
	logic                   exec;
	cmx_dec_t               dec;
	logic                   win_hit;
	logic [CMX_PTR_W-1:0]   file_ea;
	logic [CMX_PTR_W-1:0]   cur;
	logic [CMX_PTR_W-1:0]   off_ext;
	logic [CMX_PTR_W-1:0]   ptr_ea;
	logic [CMX_PTR_W-1:0]   ptr_new;
	logic [7:0]             fdata;
	logic [7:0]             idata;
	logic                   is_ind;

	// Address phase is taken only while the bus is ready
	assign accept = hsel & htrans[1] & hready;
	assign wr     = (st_q == CMX_BUS_WDATA);
	assign exec   = wr && (addr_q == CMX_OFF_INSTR);
	assign dec    = cmx_decode(hwdata[CMX_INSTR_W-1:0]);
	assign is_ind = (dec.op == CMX_OP_IND_MODE) || (dec.op == CMX_OP_IND_OFF);

	// Bus phase tracking; reads get one wait state so hrdata is a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q        <= CMX_BUS_IDLE;
			addr_q      <= CMX_RST_BYTE;
			hreadyout_q <= 1'b1;
		end else if (accept) begin
			addr_q      <= haddr[CMX_OFF_W-1:0];
			st_q        <= hwrite ? CMX_BUS_WDATA : CMX_BUS_RWAIT;
			hreadyout_q <= hwrite;
		end else begin
			st_q        <= CMX_BUS_IDLE;
			hreadyout_q <= 1'b1;
		end
	end

	// Error responses are never produced
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp_q <= 1'b0;
		end else begin
			hresp_q <= 1'b0;
		end
	end

	// Window addresses redirect to a pointer, others are banked
	assign win_hit = (dec.faddr == CMX_F_WIN0) || (dec.faddr == CMX_F_WIN1);
	always_comb begin
		if (win_hit) begin
			file_ea = ptr_q[dec.faddr[0]];
		end else begin
			file_ea = {{(CMX_PTR_W - 12){1'b0}}, bank_q, dec.faddr};
		end
	end

	// Indirect address and pointer step; sums wrap at 16 bits
	assign cur     = ptr_q[dec.ptr_sel];
	assign off_ext = {{(CMX_PTR_W - 6){dec.offset[5]}}, dec.offset};
	always_comb begin
		ptr_ea  = cur;
		ptr_new = cur;
		if (dec.op == CMX_OP_IND_OFF) begin
			ptr_ea = cur + off_ext;
		end else begin
			case (dec.mode)
				CMX_MODE_PREINC: ptr_ea = cur + CMX_PTR_ONE;
				CMX_MODE_PREDEC: ptr_ea = cur - CMX_PTR_ONE;
				default:         ptr_ea = cur;
			endcase
			ptr_new = dec.mode[0] ? cur - CMX_PTR_ONE : cur + CMX_PTR_ONE;
		end
	end

	// Addresses alias modulo the memory depth
	assign fdata = mem_q[file_ea[IDX_W-1:0]];
	assign idata = mem_q[ptr_ea[IDX_W-1:0]];

	// Work register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			w_q <= CMX_RST_BYTE;
		end else if (wr && addr_q == CMX_OFF_WORK) begin
			w_q <= hwdata[7:0];
		end else if (exec) begin
			case (dec.op)
				CMX_OP_MOVE_FILE: w_q <= dec.dest_file ? w_q : fdata;
				CMX_OP_IND_MODE:  w_q <= idata;
				CMX_OP_IND_OFF:   w_q <= idata;
				CMX_OP_LOAD_W:    w_q <= dec.lit;
				default:          w_q <= w_q;
			endcase
		end
	end

	// Zero flag; literal loads, stores and pointer steps leave it alone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zero_q <= 1'b0;
		end else if (wr && addr_q == CMX_OFF_STATUS) begin
			zero_q <= hwdata[CMX_STAT_Z];
		end else if (exec && dec.op == CMX_OP_MOVE_FILE) begin
			zero_q <= (fdata == CMX_RST_BYTE);
		end else if (exec && is_ind) begin
			zero_q <= (idata == CMX_RST_BYTE);
		end
	end

	// Bank select and page latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bank_q <= 5'h00;
			page_q <= 7'h00;
		end else begin
			if (wr && addr_q == CMX_OFF_BANK) begin
				bank_q <= hwdata[4:0];
			end else if (exec && dec.op == CMX_OP_LOAD_BANK) begin
				bank_q <= dec.lit[4:0];
			end
			if (wr && addr_q == CMX_OFF_PAGE) begin
				page_q <= hwdata[6:0];
			end else if (exec && dec.op == CMX_OP_LOAD_PAGE) begin
				page_q <= dec.lit[6:0];
			end
		end
	end

	// One pointer per entry; offset form keeps the pointer
	genvar g;
	generate
		for (g = 0; g < CMX_PTR_NUM; g++) begin : g_ptr
			localparam logic [7:0] OFF = 8'(CMX_OFF_PTR0 + CMX_REG_STRIDE * g);
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					ptr_q[g] <= CMX_RST_PTR;
				end else if (wr && addr_q == OFF) begin
					ptr_q[g] <= hwdata[CMX_PTR_W-1:0];
				end else if (exec && dec.op == CMX_OP_IND_MODE &&
					dec.ptr_sel == 1'(g)) begin
					ptr_q[g] <= ptr_new;
				end
			end
		end
	endgenerate

	// Software window into data memory
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			maddr_q <= CMX_RST_PTR;
		end else if (wr && addr_q == CMX_OFF_MADDR) begin
			maddr_q <= hwdata[CMX_PTR_W-1:0];
		end
	end

	// Data memory; reset so flag tests never see unknowns
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < MEM_DEPTH; i++) begin
				mem_q[i] <= CMX_RST_BYTE;
			end
		end else if (wr && addr_q == CMX_OFF_MDATA) begin
			mem_q[maddr_q[IDX_W-1:0]] <= hwdata[7:0];
		end else if (exec && dec.op == CMX_OP_MOVE_FILE && dec.dest_file) begin
			mem_q[file_ea[IDX_W-1:0]] <= fdata;
		end else if (exec && dec.op == CMX_OP_STORE_W) begin
			mem_q[file_ea[IDX_W-1:0]] <= w_q;
		end
	end

	// Read data is captured in the wait state, after any write before it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (st_q == CMX_BUS_RWAIT) begin
			case (addr_q)
				CMX_OFF_WORK:   hrdata_q <= {24'h00_0000, w_q};
				CMX_OFF_STATUS: hrdata_q <= {31'h0000_0000, zero_q};
				CMX_OFF_BANK:   hrdata_q <= {27'h000_0000, bank_q};
				CMX_OFF_PAGE:   hrdata_q <= {25'h000_0000, page_q};
				CMX_OFF_PTR0:   hrdata_q <= {16'h0000, ptr_q[0]};
				CMX_OFF_PTR0 + CMX_REG_STRIDE: hrdata_q <= {16'h0000, ptr_q[1]};
				CMX_OFF_MADDR:  hrdata_q <= {16'h0000, maddr_q};
				CMX_OFF_MDATA:  hrdata_q <= {24'h00_0000,
					mem_q[maddr_q[IDX_W-1:0]]};
				default:        hrdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign hrdata        = hrdata_q;
	assign hreadyout     = hreadyout_q;
	assign hresp         = hresp_q;
	assign work_reg      = w_q;
	assign zero_flag     = zero_q;
	assign bank_select   = bank_q;
	assign pc_high_latch = page_q;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_rd_take;
		accept && !hwrite;
	endsequence
	sequence s_rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence

	a_read_wait: assert property (s_rd_take |=> s_rd_answer)
		else $error("read answer not after one wait state");
	a_move_to_w: assert property (
		exec && dec.op == CMX_OP_MOVE_FILE && !dec.dest_file
		|=> w_q == $past(fdata))
		else $error("file move did not reach work register");
	a_move_zero: assert property (
		exec && dec.op == CMX_OP_MOVE_FILE
		|=> zero_q == ($past(fdata) == CMX_RST_BYTE))
		else $error("file move zero flag wrong");
	a_ind_load: assert property (
		exec && is_ind
		|=> w_q == $past(idata) && zero_q == (w_q == CMX_RST_BYTE))
		else $error("indirect load result or flag wrong");
	a_ptr_step: assert property (
		exec && dec.op == CMX_OP_IND_MODE
		|=> ptr_q[$past(dec.ptr_sel)] == ($past(dec.mode[0]) ?
		$past(cur) - CMX_PTR_ONE : $past(cur) + CMX_PTR_ONE))
		else $error("pointer step wrong");
	a_offset_keep: assert property (
		exec && dec.op == CMX_OP_IND_OFF
		|=> $stable(ptr_q[0]) && $stable(ptr_q[1]))
		else $error("offset form changed a pointer");
	a_bank_load: assert property (
		exec && dec.op == CMX_OP_LOAD_BANK
		|=> bank_q == $past(hwdata[4:0]) && $stable(zero_q))
		else $error("bank literal not loaded");
	a_page_flags: assert property (
		exec && dec.op == CMX_OP_LOAD_PAGE
		|=> page_q == $past(hwdata[6:0]) && $stable(zero_q))
		else $error("page literal load wrong");
	a_wlit_flags: assert property (
		exec && dec.op == CMX_OP_LOAD_W
		|=> w_q == $past(hwdata[7:0]) && $stable(zero_q))
		else $error("work literal load wrong");
	a_store_file: assert property (
		exec && dec.op == CMX_OP_STORE_W
		|=> mem_q[$past(file_ea[IDX_W-1:0])] == $past(w_q)
		&& $stable(zero_q))
		else $error("work store wrong");
	// A no-op must leave every piece of core state where it was
	a_nop_quiet: assert property (
		exec && dec.op == CMX_OP_NOP
		|=> $stable(w_q) && $stable(zero_q) && $stable(bank_q)
		&& $stable(page_q) && $stable(ptr_q[0]) && $stable(ptr_q[1]))
		else $error("no-op changed core state");

endmodule
`default_nettype wire

// ==== design/cmx_pkg.sv ====
`default_nettype none
package cmx_pkg;

	// Widths
	localparam int unsigned CMX_DATA_W  = 8;
	localparam int unsigned CMX_PTR_W   = 16;
	localparam int unsigned CMX_INSTR_W = 14;
	localparam int unsigned CMX_PTR_NUM = 2;
	localparam int unsigned CMX_OFF_W   = 8;

	// Register byte offsets on the bus
	localparam logic [7:0] CMX_OFF_INSTR  = 8'h00;
	localparam logic [7:0] CMX_OFF_WORK   = 8'h04;
	localparam logic [7:0] CMX_OFF_STATUS = 8'h08;
	localparam logic [7:0] CMX_OFF_BANK   = 8'h0c;
	localparam logic [7:0] CMX_OFF_PAGE   = 8'h10;
	localparam logic [7:0] CMX_OFF_PTR0   = 8'h14;
	localparam logic [7:0] CMX_OFF_MADDR  = 8'h1c;
	localparam logic [7:0] CMX_OFF_MDATA  = 8'h20;
	localparam logic [7:0] CMX_REG_STRIDE = 8'h04;

	// Instruction field positions and the status zero bit
	localparam int unsigned CMX_OP_LSB    = 11;
	localparam int unsigned CMX_DEST_BIT  = 7;
	localparam int unsigned CMX_PSEL_MODE = 2;
	localparam int unsigned CMX_PSEL_OFF  = 6;
	localparam int unsigned CMX_STAT_Z    = 0;

	// File addresses that open the indirect windows
	localparam logic [6:0] CMX_F_WIN0 = 7'h00;
	localparam logic [6:0] CMX_F_WIN1 = 7'h01;

	// Reset values and pointer step
	localparam logic [7:0]  CMX_RST_BYTE = 8'h00;
	localparam logic [15:0] CMX_RST_PTR  = 16'h0000;
	localparam logic [15:0] CMX_PTR_ONE  = 16'h0001;

	// Pointer modes of the indirect load
	localparam logic [1:0] CMX_MODE_PREINC  = 2'h0;
	localparam logic [1:0] CMX_MODE_PREDEC  = 2'h1;
	localparam logic [1:0] CMX_MODE_POSTINC = 2'h2;
	localparam logic [1:0] CMX_MODE_POSTDEC = 2'h3;

	typedef enum logic [2:0] {
		CMX_OP_NOP       = 3'h0,
		CMX_OP_MOVE_FILE = 3'h1,
		CMX_OP_IND_MODE  = 3'h2,
		CMX_OP_IND_OFF   = 3'h3,
		CMX_OP_LOAD_BANK = 3'h4,
		CMX_OP_LOAD_PAGE = 3'h5,
		CMX_OP_LOAD_W    = 3'h6,
		CMX_OP_STORE_W   = 3'h7
	} cmx_op_t;

	// Bus phase states, Gray along idle-write and idle-read
	typedef enum logic [1:0] {
		CMX_BUS_IDLE  = 2'b00,
		CMX_BUS_WDATA = 2'b01,
		CMX_BUS_RWAIT = 2'b10
	} cmx_bus_t;

	typedef struct packed {
		cmx_op_t    op;
		logic       dest_file;
		logic [6:0] faddr;
		logic       ptr_sel;
		logic [1:0] mode;
		logic [5:0] offset;
		logic [7:0] lit;
	} cmx_dec_t;

	function automatic cmx_dec_t cmx_decode(input logic [13:0] i);
		cmx_dec_t d;
		d.op        = cmx_op_t'(i[CMX_OP_LSB +: 3]);
		d.dest_file = i[CMX_DEST_BIT];
		d.faddr     = i[6:0];
		d.ptr_sel   = (d.op == CMX_OP_IND_OFF) ? i[CMX_PSEL_OFF] :
			i[CMX_PSEL_MODE];
		d.mode      = i[1:0];
		d.offset    = i[5:0];
		d.lit       = i[7:0];
		return d;
	endfunction

endpackage
`default_nettype wire

// ==== dv/cmx_move_exec_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmx_move_exec_tb_top;
	import cmx_pkg::*;

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  work_reg;
	logic        zero_flag;
	logic [4:0]  bank_select;
	logic [6:0]  pc_high_latch;
	int          n_fail;
	int          cmp_count;
	int          cyc = 0;
	logic [7:0]  dv [4] = '{8'h33, 8'h11, 8'h22, 8'h22};
	logic [15:0] pv [4] = '{16'h0031, 16'h002f, 16'h0031, 16'h002f};

	// Single slave, so its ready closes the loop as the bus ready
	cmx_move_exec dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .work_reg(work_reg),
		.zero_flag(zero_flag), .bank_select(bank_select),
		.pc_high_latch(pc_high_latch));

	// Clock, and a ceiling well above the few hundred cycles needed
	initial hclk = 1'b0;
	always #4 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	// One AHB-Lite single transfer; waits on ready, never on a count
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		// Step off the edge so callers see outputs it just updated
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rdc(input string n, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(n, x, e);
		chk("resp", {31'h0, hresp}, 32'h0);
	endtask

	task automatic mem(input logic [15:0] a, input logic [7:0] d);
		wr(CMX_OFF_MADDR, {16'h0, a});
		wr(CMX_OFF_MDATA, {24'h0, d});
	endtask

	task automatic rdm(input logic [15:0] a, input logic [7:0] e);
		wr(CMX_OFF_MADDR, {16'h0, a});
		rdc("mem", CMX_OFF_MDATA, {24'h0, e});
	endtask

	task automatic exe(input cmx_op_t op, input logic [10:0] f);
		wr(CMX_OFF_INSTR, {18'h0, op, f});
	endtask

	task automatic zc(input logic e);
		chk("zero", {31'h0, zero_flag}, {31'h0, e});
	endtask

	// Main sequence; every expectation is worked out by hand
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hresetn = 1'b0;
		hsize = 3'b010;
		n_fail = 0;
		cmp_count = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		hsel <= 1'b1;
		for (int a = 8'h04; a <= 8'h14; a += 4) begin
			rdc("reset", a[7:0], 32'h0);
		end
		wr(8'h40, 32'hffff_ffff);
		rdc("unmapped", 8'h40, 32'h0);
		mem(16'h20, 8'h5a);
		mem(16'h2f, 8'h11);
		mem(16'h30, 8'h22);
		mem(16'h31, 8'h33);
		mem(16'h5f, 8'h3c);
		mem(16'hff, 8'h81);
		// File moves to W and back onto themselves
		exe(CMX_OP_MOVE_FILE, 11'h020);
		chk("w", {24'h0, work_reg}, 32'h5a);
		zc(1'b0);
		exe(CMX_OP_MOVE_FILE, 11'h0a1);
		chk("w", {24'h0, work_reg}, 32'h5a);
		zc(1'b1);
		wr(CMX_OFF_STATUS, 32'h1);
		exe(CMX_OP_MOVE_FILE, 11'h0a0);
		zc(1'b0);
		rdm(16'h20, 8'h5a);
		wr(CMX_OFF_PTR0, 32'h5f);
		exe(CMX_OP_MOVE_FILE, 11'h000);
		rdc("window", CMX_OFF_WORK, 32'h3c);
		// All four pointer modes from the same start
		for (int m = 0; m < 4; m++) begin
			wr(CMX_OFF_PTR0, 32'h30);
			exe(CMX_OP_IND_MODE, {9'h0, m[1:0]});
			rdc("ind w", CMX_OFF_WORK, {24'h0, dv[m]});
			rdc("ptr0", CMX_OFF_PTR0, {16'h0, pv[m]});
			zc(1'b0);
		end
		// Pointer wraps both ways, second pointer selected
		wr(CMX_OFF_PTR0 + CMX_REG_STRIDE, 32'hffff);
		exe(CMX_OP_IND_MODE, 11'h004);
		rdc("wrap up", CMX_OFF_PTR0 + CMX_REG_STRIDE, 32'h0);
		zc(1'b1);
		exe(CMX_OP_IND_MODE, 11'h005);
		rdc("wrap dn", CMX_OFF_PTR0 + CMX_REG_STRIDE, 32'hffff);
		rdc("wrap w", CMX_OFF_WORK, 32'h81);
		// Offset form at both ends of the signed range
		wr(CMX_OFF_PTR0 + CMX_REG_STRIDE, 32'h40);
		exe(CMX_OP_IND_OFF, 11'h060);
		rdc("off lo", CMX_OFF_WORK, 32'h5a);
		exe(CMX_OP_IND_OFF, 11'h05f);
		rdc("off hi", CMX_OFF_WORK, 32'h3c);
		rdc("off ptr", CMX_OFF_PTR0 + CMX_REG_STRIDE, 32'h40);
		// Literal loads leave a preset flag alone
		wr(CMX_OFF_STATUS, 32'h1);
		exe(CMX_OP_LOAD_BANK, 11'h01f);
		chk("bank", {27'h0, bank_select}, 32'h1f);
		exe(CMX_OP_LOAD_PAGE, 11'h07f);
		chk("page", {25'h0, pc_high_latch}, 32'h7f);
		exe(CMX_OP_LOAD_W, 11'h0a5);
		#1;
		chk("w now", {24'h0, work_reg}, 32'ha5);
		zc(1'b1);
		wr(CMX_OFF_STATUS, 32'h0);
		exe(CMX_OP_LOAD_W, 11'h000);
		chk("w zero", {24'h0, work_reg}, 32'h0);
		zc(1'b0);
		// Stores, direct and through the window
		exe(CMX_OP_LOAD_BANK, 11'h000);
		exe(CMX_OP_LOAD_W, 11'h0c3);
		wr(CMX_OFF_STATUS, 32'h1);
		exe(CMX_OP_STORE_W, 11'h07f);
		rdm(16'h7f, 8'hc3);
		zc(1'b1);
		wr(CMX_OFF_PTR0 + CMX_REG_STRIDE, 32'h50);
		exe(CMX_OP_STORE_W, 11'h001);
		rdm(16'h50, 8'hc3);
		// A no-op leaves work register and flag alone
		exe(CMX_OP_NOP, 11'h7ff);
		rdc("nop w", CMX_OFF_WORK, 32'hc3);
		zc(1'b1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
